// ==== bench/tx_mem_model.sv ====
// Purpose : Host memory holding descriptors and buffers
// Assumes : Request held until ack; one ack per request
// Notes   : Read data is scrambled outside the ack cycle
`default_nettype none
module tx_mem_model (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        slow,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output var  logic        mem_ack,
    output var  logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:63];
    logic [2:0]  wait_cnt;
    // ==========================================================
    // Answer after 0 or 2 wait cycles; word index from byte address
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 3'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && wait_cnt >= (slow ? 3'h2 : 3'h0)) begin
            mem_ack  <= 1'b1;
            wait_cnt <= 3'h0;
            if (mem_we) begin
                mem[mem_addr[7:2]] <= mem_wdata;
            end else begin
                mem_rdata <= mem[mem_addr[7:2]];
            end
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata; // Stale data must not look valid
            if (mem_req && !mem_ack) begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end
    end
endmodule : tx_mem_model
`default_nettype wire

// ==== bench/txdma_checker.sv ====
// Purpose : Port-level checks for the transmit descriptor DMA
// Assumes : One clock domain, reset active low
// Notes   : Bound to the top module from the bench top file
`default_nettype none
module txdma_checker import txdma_pkg::*; (
    input wire logic        MCLK,
    input wire logic        RST_B,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        MEM_REQ,
    input wire logic        MEM_WE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [31:0] MEM_WDATA,
    input wire logic        MEM_ACK,
    input wire logic [31:0] TX_DATA,
    input wire logic        TX_LAST,
    input wire logic        TX_VALID,
    input wire logic        TX_READY,
    input wire logic        TX_INT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    logic [3:0] since_wr;
    // ==========================================================
    // Cycles since the last write-back; saturates so it never wraps
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            since_wr <= 4'hF;
        end else if (MEM_ACK && MEM_WE) begin
            since_wr <= 4'h0;
        end else if (since_wr != 4'hF) begin
            since_wr <= since_wr + 4'h1;
        end
    end
    // ==========================================================
    // Memory request steps
    sequence mem_waiting;
        MEM_REQ && !MEM_ACK;
    endsequence
    sequence mem_fields_kept;
        MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA);
    endsequence
    // ==========================================================
    // Assertions
    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped early");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    mem_req_hold_a: assert property (mem_waiting |=> mem_fields_kept)
        else $error("memory request changed before ack");
    tx_word_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable({TX_LAST, TX_DATA}))
        else $error("stream word lost during stall");
    owner_clear_a: assert property (MEM_REQ && MEM_WE |-> MEM_ADDR[3:0] == W3_OFFSET && !MEM_WDATA[OWN_BIT])
        else $error("write-back not a released flags word");
    eoq_on_end_a: assert property (MEM_REQ && MEM_WE && MEM_WDATA[EOQ_BIT] |-> MEM_WDATA[EOP_BIT])
        else $error("end of queue on a non-final descriptor");
    int_after_wb_a: assert property ($rose(TX_INT) |-> since_wr <= 4'h6)
        else $error("interrupt without a completed packet");
endmodule : txdma_checker
`default_nettype wire

// ==== bench/txdma_tb_top.sv ====
// Purpose : Self-checking bench for the transmit descriptor DMA
// Assumes : Host software role played by the tasks below
// Notes   : Buffer word k holds 5A00_0000 plus k
`default_nettype none
module txdma_tb_top import txdma_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_b, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic        ar_valid, ar_ready, r_valid, r_ready, mem_req, mem_we, mem_ack;
    logic        tx_last, tx_valid, tx_ready, tx_int, slow, hold_tx;
    logic [7:0]  aw_addr, ar_addr, cyc;
    logic [1:0]  b_resp, r_resp;
    logic [31:0] w_data, r_data, mem_addr, mem_wdata, mem_rdata, tx_data;
    logic [32:0] rxq [$];
    int          failures, checks_done;
    txdma_top txdma_top_i (.MCLK(mclk), .RST_B(rst_b), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
        .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .MEM_REQ(mem_req),
        .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack),
        .MEM_RDATA(mem_rdata), .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .TX_INT(tx_int));
    tx_mem_model mem_i (.mclk(mclk), .rst_b(rst_b), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // ==========================================================
    // Clock, receiver stall pattern and word capture
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        tx_ready <= !hold_tx && cyc[0];
        cyc      <= cyc + 8'h1;
        if (tx_valid && tx_ready) rxq.push_back({tx_last, tx_data});
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        @(posedge mclk);
        aw_addr  <= a;
        w_data   <= d;
        aw_valid <= 1'b1;
        w_valid  <= 1'b1;
        b_ready  <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge mclk);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
            done = b_valid; // Response taken at this edge with bready high
        end
        b_ready <= 1'b0;
        chk("bresp", {30'h0, er}, done ? {30'h0, b_resp} : 32'hFFFF_FFFF);
    endtask : axi_wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        bit done;
        @(posedge mclk);
        ar_addr  <= a;
        ar_valid <= 1'b1;
        r_ready  <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge mclk);
            if (ar_ready) ar_valid <= 1'b0;
            done = r_valid; // Data taken at this edge with rready high
        end
        r_ready <= 1'b0;
        chk("rdata", e, done ? r_data : ~e);
        chk("rresp", {30'h0, er}, done ? {30'h0, r_resp} : 32'hFFFF_FFFF);
    endtask : rdc
    // Descriptor: link, buffer, offset and length, flags
    task automatic load_desc(input logic [7:0] a, input logic [31:0] lnk, buf_p, len, w3);
        mem_i.mem[a[7:2]]        = lnk;
        mem_i.mem[a[7:2] + 6'h1] = buf_p;
        mem_i.mem[a[7:2] + 6'h2] = len;
        mem_i.mem[a[7:2] + 6'h3] = w3;
    endtask : load_desc
    // Wait for n words, then a settle span for the write-backs
    task automatic wait_words(input int n);
        for (int k = 0; k < 2000 && rxq.size() < n; k++) @(posedge mclk);
        repeat (40) @(posedge mclk);
        chk("tx_count", n, rxq.size());
    endtask : wait_words
    // ==========================================================
    // Scenarios
    task automatic regs_after_reset;
        axi_wr(HEAD_PTR0, PTR_RESET, RESP_OKAY);
        axi_wr(HEAD_PTR1, PTR_RESET, RESP_OKAY);
        rdc(COMPL_PTR0, PTR_RESET, RESP_OKAY);
        rdc(COMPL_PTR1, PTR_RESET, RESP_OKAY);
        rdc(8'h30, 32'h0, RESP_SLVERR);
        axi_wr(8'h30, 32'h40, RESP_SLVERR);
        rdc(DMA_STATUS, 32'h0, RESP_OKAY);
    endtask : regs_after_reset
    // Two packets, the first split over two descriptors, with a long stall
    task automatic queue_ch0;
        logic [7:0] ba [4] = '{8'h80, 8'h90, 8'hA0, 8'hA4};
        load_desc(8'h40, 32'h50, 32'h80, 32'h4, 32'hA000_0008);
        load_desc(8'h50, 32'h60, 32'h90, 32'h4, 32'h4000_0000);
        load_desc(8'h60, 32'h0, 32'hA0, 32'h8, 32'hE000_0008);
        hold_tx = 1'b1;
        rxq.delete();
        axi_wr(HEAD_PTR0, 32'h40, RESP_OKAY);
        repeat (80) @(posedge mclk);
        hold_tx = 1'b0;
        wait_words(4);
        for (int i = 0; i < 4; i++) begin
            chk("tx_data", 32'h5A00_0000 | ba[i][7:2], rxq[i][31:0]);
            chk("tx_last", i % 2, rxq[i][32]);
        end
        chk("w3_first", 32'h8000_0008, mem_i.mem[19]);
        chk("w3_middle", 32'h4000_0000, mem_i.mem[23]);
        chk("w3_final", 32'hD000_0008, mem_i.mem[27]);
        rdc(COMPL_PTR0, 32'h60, RESP_OKAY);
        rdc(HEAD_PTR0, 32'h0, RESP_OKAY);
        rdc(DMA_STATUS, 32'h2, RESP_OKAY);
        axi_wr(COMPL_PTR0, 32'h40, RESP_OKAY);
        chk("tx_int", 32'h1, {31'h0, tx_int});
        axi_wr(COMPL_PTR0, 32'h60, RESP_OKAY);
        @(posedge mclk);
        chk("tx_int", 32'h0, {31'h0, tx_int});
    endtask : queue_ch0
    // Single-descriptor packet on the second channel, slow memory
    task automatic single_ch1;
        load_desc(8'hC0, 32'h0, 32'hE0, 32'h4, 32'hE000_0004);
        @(posedge mclk);
        slow <= 1'b1;
        rxq.delete();
        axi_wr(HEAD_PTR1, 32'hC0, RESP_OKAY);
        wait_words(1);
        chk("tx_data", 32'h5A00_0038, rxq[0][31:0]);
        chk("tx_last", 32'h1, rxq[0][32]);
        chk("w3_single", 32'hD000_0004, mem_i.mem[51]);
        rdc(COMPL_PTR1, 32'hC0, RESP_OKAY);
        rdc(DMA_STATUS, 32'h4, RESP_OKAY);
        axi_wr(COMPL_PTR1, 32'hC0, RESP_OKAY);
        @(posedge mclk);
        chk("tx_int", 32'h0, {31'h0, tx_int});
    endtask : single_ch1
    task automatic tally_and_finish;
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        {mclk, aw_valid, w_valid, b_ready, ar_valid, r_ready, tx_ready, slow, hold_tx} = '0;
        {aw_addr, ar_addr, cyc, w_data, rst_b} = '0;
        for (int k = 0; k < 64; k++) mem_i.mem[k] = 32'h5A00_0000 | k;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        regs_after_reset();
        queue_ch0();
        single_ch1();
        tally_and_finish();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end
endmodule : txdma_tb_top
bind txdma_top txdma_checker txdma_checker_i (.MCLK(MCLK), .RST_B(RST_B), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_INT(TX_INT));
`default_nettype wire

// ==== verilog/txdma_pkg.sv ====
// Purpose : Shared constants for the transmit descriptor DMA
// Assumes : 32-bit AXI4-Lite register bus, 32-bit descriptor memory
// Notes   : Descriptors are four aligned words
`default_nettype none
package txdma_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam int          NCH          = 2;
    localparam logic [7:0]  HEAD_PTR0    = 8'h00;
    localparam logic [7:0]  HEAD_PTR1    = 8'h04;
    localparam logic [7:0]  COMPL_PTR0   = 8'h10;
    localparam logic [7:0]  COMPL_PTR1   = 8'h14;
    localparam logic [7:0]  DMA_STATUS   = 8'h20;
    localparam logic [31:0] PTR_RESET    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ==========================================================
    // Descriptor layout
    localparam logic [3:0]  W3_OFFSET    = 4'hC;
    localparam int          SOP_BIT      = 31;
    localparam int          EOP_BIT      = 30;
    localparam int          OWN_BIT      = 29;
    localparam int          EOQ_BIT      = 28;
    localparam int          SHUT_BIT     = 27;
    localparam int          KEEPCRC_BIT  = 26;
    localparam int          OFFS_LSB     = 16;
    localparam int          LEN_LSB      = 0;
    localparam int          FIELD_W      = 16;
    localparam int          STREAM_W     = 33;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_DESC = 3'h1,
        S_BUF  = 3'h2,
        S_PUSH = 3'h3,
        S_FEND = 3'h4,
        S_EOQ  = 3'h5,
        S_SOP  = 3'h6,
        S_DONE = 3'h7
    } seq_e;
endpackage : txdma_pkg
`default_nettype wire

// ==== verilog/txdma_skid2.sv ====
// Purpose : Two-entry buffer in the transmit data path
// Assumes : Single clock, asynchronous active-low reset
// Notes   : Input ready depends only on occupancy, so no comb loop
`default_nettype none
module txdma_skid2 import txdma_pkg::*; (
    input  wire logic                MCLK,
    input  wire logic                RST_B,
    txdma_stream_if.snk              in_s,
    output var  logic [STREAM_W-1:0] out_payload,
    output var  logic                out_valid,
    input  wire logic                out_ready
);
    logic [STREAM_W-1:0] mem [2];
    logic                rd_ptr;
    logic                wr_ptr;
    logic [1:0]          count;
    logic                push;
    logic                pop;

    // ==========================================================
    // Handshakes
    assign in_s.ready  = (count != 2'h2);
    assign out_valid   = (count != 2'h0);
    assign out_payload = mem[rd_ptr];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_valid && out_ready;

    // Storage has no reset; count guards reads
    always_ff @(posedge MCLK) begin
        if (push) begin
            mem[wr_ptr] <= in_s.payload;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : txdma_skid2
`default_nettype wire

// ==== verilog/txdma_stream_if.sv ====
// Purpose : Valid/ready word stream between the sequencer and the buffer
// Assumes : Single clock
// Notes   : Payload is last flag over a 32-bit word
`default_nettype none
interface txdma_stream_if;
    import txdma_pkg::*;
    logic [STREAM_W-1:0] payload;
    logic                valid;
    logic                ready;
    modport src (output payload, output valid, input ready);
    modport snk (input payload, input valid, output ready);
endinterface : txdma_stream_if
`default_nettype wire

// ==== verilog/txdma_top.sv ====
// Purpose : Transmit descriptor DMA for the switch host port
// Assumes : MCLK 250 MHz, memory port answers each request with MEM_ACK
// Notes   : Channels are served one whole queue at a time, lowest index first
//
// How it works
// - A nonzero head pointer write starts that channel's transmission.
// - Engine follows links, sending packets until the queue is empty.
// - After a packet, owns flag is cleared in its first descriptor.
// - After a packet, the last descriptor address goes to the completion pointer.
// - Queue's last packet gets end-of-queue set in its last descriptor.
// - Interrupt stays high while host and engine completion addresses differ.
// - Word 3 holds start bit 31, end bit 30, owns bit 29, then the rest.
`default_nettype none
module txdma_top import txdma_pkg::*; (
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // AXI4-Lite register slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Descriptor and buffer memory
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic [31:0]      MEM_ADDR,
    output logic [31:0]      MEM_WDATA,
    input  wire logic        MEM_ACK,
    input  wire logic [31:0] MEM_RDATA,
    // Transmit word stream
    output logic [31:0]      TX_DATA,
    output logic             TX_LAST,
    output logic             TX_VALID,
    input  wire logic        TX_READY,
    // Completion interrupt
    output logic             TX_INT
);
    logic [31:0]      head [NCH];
    logic [31:0]      dev_cp [NCH];
    logic [31:0]      host_cp [NCH];
    logic [31:0]      desc [4];
    logic [31:0]      cur;
    logic [31:0]      sop_addr;
    logic [31:0]      sop_w3;
    logic [31:0]      baddr;
    logic [31:0]      hold;
    logic [FIELD_W-1:0] words_left;
    logic [1:0]       wi;
    logic             ch;
    seq_e             state;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic             aw_full;
    logic             w_full;
    logic             do_write;
    logic [NCH-1:0]   pend;
    logic [STREAM_W-1:0] tx_payload;
    txdma_stream_if   push_s ();

    // Map a byte address to a pointer slot; bit 2 = channel
    function automatic logic is_ptr(input logic [7:0] a, input logic [7:0] base);
        return (a == base) || (a == base + 8'h04);
    endfunction : is_ptr

    // ==========================================================
    // AXI4-Lite write channel: address and data taken in any order
    assign S_AXI_AWREADY = !aw_full;
    assign S_AXI_WREADY  = !w_full;
    assign do_write      = aw_full && w_full && !S_AXI_BVALID;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && !aw_full) begin
                aw_addr <= S_AXI_AWADDR;
                aw_full <= 1'b1;
            end
            if (S_AXI_WVALID && !w_full) begin
                w_data <= S_AXI_WDATA;
                w_full <= 1'b1;
            end
            if (do_write) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (is_ptr(aw_addr, HEAD_PTR0) || is_ptr(aw_addr, COMPL_PTR0))
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Read channel; one outstanding read, answer one cycle after address
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0000_0000;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= RESP_OKAY;
            if (is_ptr(S_AXI_ARADDR, HEAD_PTR0)) begin
                S_AXI_RDATA <= head[S_AXI_ARADDR[2]];
            end else if (is_ptr(S_AXI_ARADDR, COMPL_PTR0)) begin
                S_AXI_RDATA <= dev_cp[S_AXI_ARADDR[2]];
            end else if (S_AXI_ARADDR == DMA_STATUS) begin
                // Busy in bit 0, per-channel interrupt pending above
                S_AXI_RDATA <= {29'h0, dev_cp[1] != host_cp[1], dev_cp[0] != host_cp[0],
                                state != S_IDLE};
            end else begin
                S_AXI_RDATA <= 32'h0000_0000;
                S_AXI_RRESP <= RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ==========================================================
    // Host side of the completion handshake; host write is the acknowledge
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            host_cp <= '{default: PTR_RESET};
        end else if (do_write && is_ptr(aw_addr, COMPL_PTR0)) begin
            host_cp[aw_addr[2]] <= w_data;
        end
    end

    // Interrupt follows the mismatch, no sticky state
    assign TX_INT = (dev_cp[0] != host_cp[0]) || (dev_cp[1] != host_cp[1]);

    // ==========================================================
    // Head pointers: software loads, engine advances along the links
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            head <= '{default: PTR_RESET};
        end else if (do_write && is_ptr(aw_addr, HEAD_PTR0)) begin
            head[aw_addr[2]] <= w_data;
        end else if (state == S_DONE) begin
            head[ch] <= desc[0];
        end else if (state == S_FEND && !desc[3][EOP_BIT] && desc[0] == PTR_RESET) begin
            head[ch] <= PTR_RESET; // Broken chain ends the queue
        end
    end

    assign pend = {head[1] != PTR_RESET, head[0] != PTR_RESET};

    // ==========================================================
    // Memory request, held until MEM_ACK
    always_comb begin
        MEM_REQ   = 1'b0;
        MEM_WE    = 1'b0;
        MEM_ADDR  = cur + {28'h0, wi, 2'h0};
        MEM_WDATA = 32'h0000_0000;
        case (state)
            S_DESC: begin
                MEM_REQ = 1'b1;
            end
            S_BUF: begin
                MEM_REQ  = 1'b1;
                MEM_ADDR = baddr;
            end
            S_EOQ: begin
                // Single-descriptor packet: release hw_owns_descriptor in the same write
                MEM_REQ   = 1'b1;
                MEM_WE    = 1'b1;
                MEM_ADDR  = cur + {28'h0, W3_OFFSET};
                MEM_WDATA = desc[3] | (32'h1 << EOQ_BIT);
                if (cur == sop_addr) begin
                    MEM_WDATA[OWN_BIT] = 1'b0;
                end
            end
            S_SOP: begin
                MEM_REQ   = 1'b1;
                MEM_WE    = 1'b1;
                MEM_ADDR  = sop_addr + {28'h0, W3_OFFSET};
                MEM_WDATA = sop_w3 & ~(32'h1 << OWN_BIT);
            end
            default: begin
                MEM_REQ = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Sequencer: fetch descriptor, stream buffer, write back, complete
    assign push_s.valid   = (state == S_PUSH);
    assign push_s.payload = {desc[3][EOP_BIT] && words_left == '0, hold};

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state      <= S_IDLE;
            ch         <= 1'b0;
            cur        <= PTR_RESET;
            wi         <= 2'h0;
            desc       <= '{default: 32'h0};
            sop_addr   <= PTR_RESET;
            sop_w3     <= 32'h0;
            baddr      <= 32'h0;
            hold       <= 32'h0;
            words_left <= '0;
            dev_cp     <= '{default: PTR_RESET};
        end else begin
            case (state)
                S_IDLE: begin
                    if (pend != '0) begin
                        ch    <= !pend[0];
                        cur   <= pend[0] ? head[0] : head[1];
                        wi    <= 2'h0;
                        state <= S_DESC;
                    end
                end
                S_DESC: begin
                    if (MEM_ACK) begin
                        desc[wi] <= MEM_RDATA;
                        wi       <= wi + 2'h1;
                        if (wi == 2'h3) begin
                            if (MEM_RDATA[SOP_BIT]) begin
                                sop_addr <= cur;
                                sop_w3   <= MEM_RDATA;
                            end
                            baddr      <= desc[1] + {16'h0, desc[2][OFFS_LSB +: FIELD_W]};
                            words_left <= FIELD_W'((32'(desc[2][LEN_LSB +: FIELD_W]) + 32'd3) >> 2);
                            state      <= (desc[2][LEN_LSB +: FIELD_W] == '0) ? S_FEND : S_BUF;
                        end
                    end
                end
                S_BUF: begin
                    if (MEM_ACK) begin
                        hold       <= MEM_RDATA;
                        baddr      <= baddr + 32'h4;
                        words_left <= words_left - FIELD_W'(1);
                        state      <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    // Buffer full stalls here, nothing is dropped
                    if (push_s.ready) begin
                        state <= (words_left == '0) ? S_FEND : S_BUF;
                    end
                end
                S_FEND: begin
                    wi <= 2'h0;
                    if (desc[3][EOP_BIT]) begin
                        state <= (desc[0] == PTR_RESET) ? S_EOQ : S_SOP;
                    end else if (desc[0] == PTR_RESET) begin
                        state <= S_IDLE;
                    end else begin
                        cur   <= desc[0];
                        state <= S_DESC;
                    end
                end
                S_EOQ: begin
                    if (MEM_ACK) begin
                        state <= (cur == sop_addr) ? S_DONE : S_SOP;
                    end
                end
                S_SOP: begin
                    if (MEM_ACK) begin
                        state <= S_DONE;
                    end
                end
                S_DONE: begin
                    dev_cp[ch] <= cur;
                    cur        <= desc[0];
                    wi         <= 2'h0;
                    state      <= (desc[0] == PTR_RESET) ? S_IDLE : S_DESC;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Output buffer so a stalled receiver loses no word
    txdma_skid2 u_skid (
        .MCLK        (MCLK),
        .RST_B       (RST_B),
        .in_s        (push_s),
        .out_payload (tx_payload),
        .out_valid   (TX_VALID),
        .out_ready   (TX_READY)
    );

    assign TX_DATA = tx_payload[31:0];
    assign TX_LAST = tx_payload[32];
endmodule : txdma_top
`default_nettype wire
